// >>> hmp_host_port.sv
`timescale 1ns/1ps
module hmp_host_port (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Straps
	input wire logic host_width_strap,
	input wire logic boot_source_strap,
	input wire logic memory_map_strap,
	input wire logic strobe_style_strap,
	input wire logic addr_data_layout_strap,
	// Host pins
	input wire logic host_sel_n,
	input wire logic host_read_or_dir_pin,
	input wire logic host_write_or_dstrobe_pin,
	input wire logic host_addr2_or_latch_pin,
	input wire logic [1:0] host_addr_low_pins,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic [15:0] host_data_oe,
	output logic host_port_ack,
	// Core side
	output logic boot_from_host,
	output logic boot_from_memory,
	output logic core_soft_reset,
	output logic core_mailbox_req
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		hmp_pkg::hmp_hstate_type st;
		logic [2:0] ha;
		logic hwr;
		logic [15:0] hwd;
		logic [15:0] hdout;
		logic [15:0] hoe;
		logic ack;
		logic [5:0] host_flags;
		logic [5:0] core_flags;
		logic [5:0] mask;
		logic [2:0] srst_cnt;
		logic [4:0] straps;
		logic strap_ok;
		logic aw_pend;
		logic [3:0] a_idx;
		logic rd_mem;
		logic [31:0] rdat;
	} hmp_state_type;
	hmp_state_type q, d;

	logic sel_s, first_s, second_s, ale_s, width8, style, muxed;
	logic active, is_wr, addr_ph, mem_h_we, mem_c_we;
	logic [2:0] pin_addr;
	logic [15:0] mem_h_wd, mem_h_rd;
	logic [31:0] mem_c_rd;
	logic [15:0] mem_c_rd16;
	logic [3:0] cur_idx;

	// Synchronised host controls, select made active high, strobes left active low
	assign sel_s = ~q.s2[0];
	assign first_s = q.s2[1];
	assign second_s = q.s2[2];
	assign ale_s = q.s2[3];
	assign width8 = q.straps[hmp_pkg::CFG_WIDTH];
	assign style = q.straps[hmp_pkg::CFG_STYLE];
	assign muxed = q.straps[hmp_pkg::CFG_LAYOUT];
	// Combined: first pin is direction, second the data strobe
	assign active = q.strap_ok && sel_s && // R14
		(style ? ~second_s : (~first_s | ~second_s)); // R03 R04 R05
	assign is_wr = style ? ~first_s : ~second_s; // R04 R05
	assign pin_addr = {host_addr2_or_latch_pin, host_addr_low_pins};
	assign addr_ph = hsel && htrans[1] && hready;
	assign cur_idx = haddr[5:2];
	assign mem_h_we = q.st == hmp_pkg::HS_XFER && q.hwr &&
		int'(q.ha) < hmp_pkg::NUM_DATA;
	assign mem_h_wd = q.hwd;
	assign mem_c_we = q.aw_pend && int'(q.a_idx) < hmp_pkg::NUM_DATA;
	assign mem_c_rd = {16'h0000, mem_c_rd16};

	hmp_mailbox #(
		.DEPTH(hmp_pkg::NUM_DATA),
		.WIDTH(hmp_pkg::DATA_W),
		.AW(hmp_pkg::ADDR_W)
	) u_mailbox (
		.clk(hclk),
		.rst_n(hresetn),
		.host_we(mem_h_we), // R11
		.host_waddr(q.ha),
		.host_wdata(mem_h_wd),
		.host_raddr(q.ha),
		.host_rdata(mem_h_rd),
		.core_we(mem_c_we), // R11
		.core_waddr(q.a_idx[2:0]),
		.core_wdata(hwdata[15:0]),
		.core_raddr(cur_idx[2:0]),
		.core_rdata(mem_c_rd16)
	);

	always_comb
	begin
		logic [5:0] hset, hclr, cset, cclr;
		hset = '0;
		hclr = '0;
		cset = '0;
		cclr = '0;
		d = q;
		// Async host pins: two flops before any decision
		d.s1 = {host_addr2_or_latch_pin, host_write_or_dstrobe_pin,
			host_read_or_dir_pin, host_sel_n}; // R10
		d.s2 = q.s1; // R10
		// Straps caught once after reset release
		if (!q.strap_ok)
		begin
			d.straps = {addr_data_layout_strap, strobe_style_strap,
				memory_map_strap, boot_source_strap, host_width_strap};
			d.strap_ok = 1'b1;
		end
		// Address latch while latch enable high
		if (muxed && ale_s && q.st == hmp_pkg::HS_IDLE)
			d.ha = host_data_in[2:0]; // R06 R07
		// Count down first so a new request below reloads it
		if (q.srst_cnt != 3'h0)
			d.srst_cnt = q.srst_cnt - 3'h1; // R13
		case (q.st)
			hmp_pkg::HS_IDLE:
			begin
				if (active)
				begin
					d.st = hmp_pkg::HS_XFER;
					d.hwr = is_wr;
					if (!muxed)
						d.ha = pin_addr; // R06
					// Byte writes clear the upper half
					d.hwd = width8 ? {8'h00, host_data_in[7:0]} :
						host_data_in; // R01 R09
				end
			end
			hmp_pkg::HS_XFER:
			begin
				if (q.hwr)
				begin
					d.st = hmp_pkg::HS_ACK;
					if (int'(q.ha) < hmp_pkg::NUM_DATA)
						hset[q.ha] = 1'b1;
					else if (q.ha == hmp_pkg::HOST_STAT_CORE &&
						q.hwd[hmp_pkg::SRST_BIT])
						d.srst_cnt = hmp_pkg::SRST_CYCLES; // R13
				end
				else
					d.st = hmp_pkg::HS_LOAD;
			end
			hmp_pkg::HS_LOAD:
			begin
				d.st = hmp_pkg::HS_ACK;
				d.ack = 1'b1; // R15
				if (q.ha == hmp_pkg::HOST_STAT_HOST)
					d.hdout = {10'h000, q.host_flags};
				else if (q.ha == hmp_pkg::HOST_STAT_CORE)
					d.hdout = {10'h000, q.core_flags};
				else
				begin
					d.hdout = mem_h_rd;
					cclr[q.ha] = 1'b1;
				end
				if (width8)
					d.hdout[15:8] = 8'h00;
				d.hoe = width8 ? hmp_pkg::OE_BYTE : hmp_pkg::OE_WORD; // R08
			end
			hmp_pkg::HS_ACK:
			begin
				d.ack = 1'b1; // R15
				if (!active)
				begin
					d.st = hmp_pkg::HS_IDLE;
					d.ack = 1'b0;
					d.hoe = '0;
				end
			end
			default:
				d.st = hmp_pkg::HS_IDLE;
		endcase
		// Core side over the register bus
		d.aw_pend = 1'b0;
		if (q.aw_pend)
		begin
			if (int'(q.a_idx) < hmp_pkg::NUM_DATA)
				cset[q.a_idx[2:0]] = 1'b1;
			else if (q.a_idx == hmp_pkg::IDX_MASK)
				d.mask = hwdata[5:0]; // R12
		end
		if (addr_ph)
		begin
			d.aw_pend = hwrite && haddr[31:6] == 26'h0;
			d.a_idx = cur_idx;
			d.rd_mem = 1'b0;
			d.rdat = '0;
			if (!hwrite && haddr[31:6] == 26'h0)
			begin
				if (int'(cur_idx) < hmp_pkg::NUM_DATA)
				begin
					d.rd_mem = 1'b1;
					hclr[cur_idx[2:0]] = 1'b1;
				end
				else if (cur_idx == hmp_pkg::IDX_STAT_HOST)
					d.rdat = {26'h0, q.host_flags};
				else if (cur_idx == hmp_pkg::IDX_STAT_CORE)
					d.rdat = {26'h0, q.core_flags};
				else if (cur_idx == hmp_pkg::IDX_MASK)
					d.rdat = {26'h0, q.mask};
				else if (cur_idx == hmp_pkg::IDX_CONFIG)
					d.rdat = {25'h0, q.srst_cnt != 3'h0, boot_from_host,
						q.straps};
			end
		end
		// Set wins over a same-cycle clear
		d.host_flags = (q.host_flags & ~hclr) | hset; // R11
		d.core_flags = (q.core_flags & ~cclr) | cset; // R11
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q <= '0;
			q.s1 <= 4'h7;
			q.s2 <= 4'h7;
			q.mask <= hmp_pkg::MASK_RESET;
		end
		else
			q <= d;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rd_mem ? mem_c_rd : q.rdat;
	assign host_data_out = q.hdout;
	assign host_data_oe = q.hoe;
	assign host_port_ack = q.ack;
	// Boot path only meaningful with map strap low
	assign boot_from_host = q.strap_ok && !q.straps[hmp_pkg::CFG_MAP] &&
		q.straps[hmp_pkg::CFG_BOOT]; // R02
	assign boot_from_memory = q.strap_ok && !q.straps[hmp_pkg::CFG_MAP] &&
		!q.straps[hmp_pkg::CFG_BOOT]; // R02
	assign core_soft_reset = q.srst_cnt != 3'h0;
	// Unmasked pending host writes call the core
	assign core_mailbox_req = |(q.host_flags & ~q.mask); // R12

	property p_oe_byte;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == hmp_pkg::HS_LOAD && width8) |=>
			host_data_oe == 16'h00FF && host_data_out[15:8] == 8'h00;
	endproperty
	a_oe_byte: assert property (p_oe_byte) else $error("byte read oe"); // R08

	property p_oe_word;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == hmp_pkg::HS_LOAD && !width8) |=>
			host_data_oe == 16'hFFFF && host_port_ack;
	endproperty
	a_oe_word: assert property (p_oe_word) else $error("word read oe"); // R01

	property p_byte_write;
		@(posedge hclk) disable iff (!hresetn)
		(mem_h_we && width8) |-> mem_h_wd[15:8] == 8'h00;
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte wr hi"); // R09

	property p_srst_len;
		@(posedge hclk) disable iff (!hresetn)
		$rose(core_soft_reset) |-> core_soft_reset[*5] ##1 !core_soft_reset;
	endproperty
	a_srst_len: assert property (p_srst_len) else $error("srst length"); // R13

	property p_boot;
		@(posedge hclk) disable iff (!hresetn)
		q.strap_ok |-> boot_from_host == (!memory_map_strap &&
			boot_source_strap) || $changed(boot_source_strap) ||
			$changed(memory_map_strap);
	endproperty
	a_boot: assert property (p_boot) else $error("boot select"); // R02

	property p_ack_soon;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == hmp_pkg::HS_IDLE && active) |-> ##[2:3] host_port_ack;
	endproperty
	a_ack_soon: assert property (p_ack_soon) else $error("ack late"); // R15

	property p_ack_drop;
		@(posedge hclk) disable iff (!hresetn)
		(host_port_ack && !active) |=> !host_port_ack && host_data_oe == '0;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack stuck"); // R15

	property p_sep_read;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == hmp_pkg::HS_IDLE && active && !style && !first_s &&
			second_s) |=> !q.hwr;
	endproperty
	a_sep_read: assert property (p_sep_read) else $error("read strobe"); // R04

	property p_mux_addr;
		@(posedge hclk) disable iff (!hresetn)
		(muxed && ale_s && q.st == hmp_pkg::HS_IDLE) |=>
			q.ha == $past(host_data_in[2:0]);
	endproperty
	a_mux_addr: assert property (p_mux_addr) else $error("ale latch"); // R07

	property p_core_flag;
		@(posedge hclk) disable iff (!hresetn)
		(mem_c_we) |=> q.core_flags[$past(q.a_idx[2:0])];
	endproperty
	a_core_flag: assert property (p_core_flag) else $error("core flag"); // R11

	property p_no_sel;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == hmp_pkg::HS_IDLE && !sel_s) |=> q.st == hmp_pkg::HS_IDLE;
	endproperty
	a_no_sel: assert property (p_no_sel) else $error("no select"); // R14

	property p_comb_write;
		@(posedge hclk) disable iff (!hresetn)
		(q.st == hmp_pkg::HS_IDLE && active && style && !first_s) |=> q.hwr;
	endproperty
	a_comb_write: assert property (p_comb_write) else $error("dir write"); // R04

	property p_host_flag;
		@(posedge hclk) disable iff (!hresetn)
		(mem_h_we) |=> q.host_flags[$past(q.ha)];
	endproperty
	a_host_flag: assert property (p_host_flag) else $error("host flag"); // R11

	c_mux_latch: cover property (@(posedge hclk) disable iff (!hresetn)
		muxed && ale_s && q.st == hmp_pkg::HS_IDLE);
	c_host_write: cover property (@(posedge hclk) disable iff (!hresetn)
		mem_h_we ##[1:8] !host_port_ack);
	c_byte_read: cover property (@(posedge hclk) disable iff (!hresetn)
		q.st == hmp_pkg::HS_LOAD && width8);
	c_soft_reset: cover property (@(posedge hclk) disable iff (!hresetn)
		$fell(core_soft_reset));
endmodule

// >>> hmp_mailbox.sv
`timescale 1ns/1ps
// Summary of operation
// R01 - Width strap: low 16-bit words, high bytes
// R02 - Map strap low: boot strap picks boot path
// R03 - Style strap: separate strobes or direction plus strobe
// R04 - First strobe pin: read, or direction select
// R05 - Second strobe pin: write, or data strobe
// R06 - Layout strap: separate address or multiplexed bus
// R07 - Multiplexed: address pin two becomes latch enable
// R08 - Byte reads drive only low eight lines
// R09 - Byte writes store upper eight bits zero
// R10 - Host side asynchronous, strobes synchronised
// R11 - Dual-ported mailbox shared by host and core
// R12 - Six data, two status registers, mask
// R13 - Host software reset lasts five core cycles
// R14 - Host selects port; strobes otherwise ignored
// R15 - Acknowledge marks completed access; host waits
package hmp_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int NUM_DATA = 6;
	localparam logic [2:0] HOST_STAT_HOST = 3'h6;
	localparam logic [2:0] HOST_STAT_CORE = 3'h7;
	localparam int SRST_BIT = 7;
	localparam logic [2:0] SRST_CYCLES = 3'h5;
	localparam logic [3:0] IDX_STAT_HOST = 4'h6;
	localparam logic [3:0] IDX_STAT_CORE = 4'h7;
	localparam logic [3:0] IDX_MASK = 4'h8;
	localparam logic [3:0] IDX_CONFIG = 4'h9;
	localparam logic [5:0] MASK_RESET = 6'h3F;
	localparam logic [15:0] OE_BYTE = 16'h00FF;
	localparam logic [15:0] OE_WORD = 16'hFFFF;
	localparam int CFG_WIDTH = 0;
	localparam int CFG_BOOT = 1;
	localparam int CFG_MAP = 2;
	localparam int CFG_STYLE = 3;
	localparam int CFG_LAYOUT = 4;
	localparam int CFG_BOOT_HOST = 5;
	localparam int CFG_SRST_BUSY = 6;
	typedef enum logic [1:0] {HS_IDLE, HS_XFER, HS_LOAD, HS_ACK} hmp_hstate_type;
endpackage

module hmp_mailbox #(
	parameter int DEPTH = 6,
	parameter int WIDTH = 16,
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host port
	input wire logic host_we,
	input wire logic [AW-1:0] host_waddr,
	input wire logic [WIDTH-1:0] host_wdata,
	input wire logic [AW-1:0] host_raddr,
	output logic [WIDTH-1:0] host_rdata,
	// Core port
	input wire logic core_we,
	input wire logic [AW-1:0] core_waddr,
	input wire logic [WIDTH-1:0] core_wdata,
	input wire logic [AW-1:0] core_raddr,
	output logic [WIDTH-1:0] core_rdata
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd_h;
		logic [WIDTH-1:0] rd_c;
	} hmp_mb_type;
	hmp_mb_type q, d;

	always_comb
	begin
		d = q;
		for (int i = 0; i < DEPTH; i++)
		begin
			// Host wins a same-cycle collision on one word
			if (host_we && host_waddr == AW'(i))
				d.mem[i] = host_wdata;
			else if (core_we && core_waddr == AW'(i))
				d.mem[i] = core_wdata;
		end
		d.rd_h = '0;
		d.rd_c = '0;
		if (int'(host_raddr) < DEPTH)
			d.rd_h = q.mem[host_raddr];
		if (int'(core_raddr) < DEPTH)
			d.rd_c = q.mem[core_raddr];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign host_rdata = q.rd_h;
	assign core_rdata = q.rd_c;
endmodule

// >>> hmp_host_model.sv
`timescale 1ns/1ps
module hmp_host_model (
	// Clock and mode
	input wire logic clk,
	input wire logic combined,
	input wire logic muxed,
	// Host pins
	output logic sel_n,
	output logic rd_dir,
	output logic wr_ds,
	output logic ale,
	output logic [1:0] alo,
	output logic [15:0] bus,
	input wire logic [15:0] dout,
	input wire logic [15:0] doe,
	input wire logic ack
);
	logic [15:0] drv_q;
	logic drv_en;
	logic [15:0] last_q;
	initial
	begin
		sel_n = 1'b1;
		rd_dir = 1'b1;
		wr_ds = 1'b1;
		ale = 1'b0;
		alo = 2'h0;
		drv_q = 16'h0000;
		drv_en = 1'b0;
		last_q = 16'h0000;
	end
	// Undriven lines toggle so a stale value never passes
	always_comb
		for (int i = 0; i < 16; i++)
			bus[i] = doe[i] ? dout[i] : drv_en ? drv_q[i] : ~last_q[i];
	always @(posedge clk)
		last_q <= bus;
	task automatic xfer(input logic rd, input logic sel,
		input logic [2:0] a, input logic [15:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b1;
		if (muxed)
		begin
			@(posedge clk);
			sel_n <= ~sel;
			drv_en <= 1'b1;
			drv_q <= {13'h0000, a};
			ale <= 1'b1;
			repeat (4) @(posedge clk);
			ale <= 1'b0;
			repeat (4) @(posedge clk);
		end
		@(posedge clk);
		sel_n <= ~sel;
		ale <= muxed ? 1'b0 : a[2];
		alo <= a[1:0];
		drv_en <= ~rd;
		drv_q <= d;
		rd_dir <= combined ? rd : ~rd;
		wr_ds <= combined ? 1'b0 : rd;
		n = 0;
		while (sel && !ack && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		ok = !sel || ack;
		q = {doe, bus};
		if (!sel)
			repeat (10) @(posedge clk);
		sel_n <= 1'b1;
		rd_dir <= 1'b1;
		wr_ds <= 1'b1;
		drv_en <= 1'b0;
		n = 0;
		while (ack && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (ack)
			ok = 1'b0;
	endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [4:0] strap;
		logic [2:0] a;
		logic [15:0] d;
	} hmp_row_type;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q, m;
	logic [1:0] htrans, alo;
	logic [2:0] hsize;
	logic sel_n, rd_dir, wr_ds, ale, ack, bfh, bfm, srst, req;
	logic [15:0] bus, dout, doe;
	logic [4:0] st;
	int err_total, num_checks, srst_cnt;
	hmp_row_type rows [5];
	hmp_row_type r;
	hmp_host_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .host_width_strap(st[0]),
		.boot_source_strap(st[1]), .memory_map_strap(st[2]),
		.strobe_style_strap(st[3]), .addr_data_layout_strap(st[4]),
		.host_sel_n(sel_n), .host_read_or_dir_pin(rd_dir),
		.host_write_or_dstrobe_pin(wr_ds), .host_addr2_or_latch_pin(ale),
		.host_addr_low_pins(alo), .host_data_in(bus),
		.host_data_out(dout), .host_data_oe(doe), .host_port_ack(ack),
		.boot_from_host(bfh), .boot_from_memory(bfm),
		.core_soft_reset(srst), .core_mailbox_req(req));
	hmp_host_model u_host (.clk(hclk), .combined(st[3]), .muxed(st[4]),
		.sel_n(sel_n), .rd_dir(rd_dir), .wr_ds(wr_ds), .ale(ale),
		.alo(alo), .bus(bus), .dout(dout), .doe(doe), .ack(ack));
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk)
		if (srst)
			srst_cnt <= srst_cnt + 1;
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hang_out();
		chk("timeout", 32'h0, 32'h1);
		wrap_up();
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (!hreadyout && n < 50);
		if (!hreadyout)
			hang_out();
	endtask
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	task automatic ahb_w(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		ahb(1'b1, a, d, v);
	endtask
	task automatic ahb_chk(input string nm, input logic [31:0] a,
		input logic [31:0] e);
		logic [31:0] v;
		ahb(1'b0, a, 32'h0, v);
		chk(nm, e, v);
	endtask
	task automatic host(input logic rd, input logic s,
		input logic [2:0] a, input logic [15:0] d);
		logic ok;
		u_host.xfer(rd, s, a, d, q, ok);
		if (!ok)
			hang_out();
	endtask
	task automatic do_reset(input logic [4:0] s);
		@(posedge hclk);
		hresetn <= 1'b0;
		st <= s;
		repeat (12) @(posedge hclk);
		chk("rst", 32'h40, {9'h0, doe, hreadyout, hresp, ack, srst, req,
			bfh, bfm});
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		st = 5'h00;
		err_total = 0;
		num_checks = 0;
		srst_cnt = 0;
		rows[0] = '{5'h00, 3'h0, 16'hA5C3};
		rows[1] = '{5'h03, 3'h2, 16'hBEEF};
		rows[2] = '{5'h0C, 3'h3, 16'h5A0F};
		rows[3] = '{5'h19, 3'h4, 16'h1234};
		rows[4] = '{5'h16, 3'h5, 16'hC0DE};
		foreach (rows[i])
		begin
			r = rows[i];
			do_reset(r.strap);
			m = r.strap[0] ? 32'h00FF : 32'hFFFF;
			ahb_chk("cfg", 32'h24, {26'h0, ~r.strap[2] & r.strap[1],
				r.strap});
			chk("boot", {30'h0, ~r.strap[2] & r.strap[1],
				~r.strap[2] & ~r.strap[1]}, {30'h0, bfh, bfm});
			host(1'b0, 1'b1, r.a, r.d);
			ahb_chk("hflag", 32'h18, 32'h1 << r.a);
			ahb_chk("hdata", {27'h0, r.a, 2'h0}, {16'h0, r.d} & m);
			ahb_chk("hflag0", 32'h18, 32'h0);
			ahb_w({27'h0, r.a, 2'h0}, {16'h0, ~r.d});
			ahb_chk("cflag", 32'h1C, 32'h1 << r.a);
			host(1'b1, 1'b1, r.a, 16'h0000);
			chk("oe", m, {16'h0, q[31:16]});
			chk("hrd", {16'h0, ~r.d} & m, {16'h0, q[15:0]} & m);
			ahb_chk("cflag0", 32'h1C, 32'h0);
		end
		do_reset(5'h00);
		ahb_chk("mask", 32'h20, 32'h3F);
		host(1'b0, 1'b0, 3'h1, 16'h1111);
		ahb_chk("nosel", 32'h18, 32'h0);
		host(1'b0, 1'b1, 3'h1, 16'h1111);
		chk("req0", 32'h0, {31'h0, req});
		host(1'b1, 1'b1, 3'h6, 16'h0000);
		chk("hstat", 32'h2, {16'h0, q[15:0]});
		ahb_w(32'h20, 32'h3D);
		repeat (2) @(posedge hclk);
		chk("req1", 32'h1, {31'h0, req});
		ahb_chk("d1", 32'h04, 32'h1111);
		repeat (2) @(posedge hclk);
		chk("req2", 32'h0, {31'h0, req});
		ahb_w(32'h18, 32'hFF);
		ahb_chk("ro", 32'h18, 32'h0);
		ahb_chk("unmap", 32'h28, 32'h0);
		srst_cnt = 0;
		host(1'b0, 1'b1, 3'h7, 16'h0080);
		repeat (10) @(posedge hclk);
		chk("srst", 32'h5, 32'(srst_cnt));
		ahb_chk("hf7", 32'h18, 32'h0);
		wrap_up();
	end
endmodule
